// ==== logic/sram_burst_map.vh ====
/*
 constants for the flow-through burst sram port: widths, lane layout,
 sleep entry and exit counts. assumes nothing but inclusion by name.
*/
`ifndef SRAM_BURST_MAP_VH
`define SRAM_BURST_MAP_VH
`define ADDR_W 18
`define DATA_W 32
`define LANES 4
`define LANE_W 8
`define WORDS 262144
`define BURST_W 2
`define BURST_ONE 2'h1
`define ZZ_NS 20
`define CLK_NS 10
`define ZZ_CYC ((`ZZ_NS + `CLK_NS - 1) / `CLK_NS)
`define ZZ_CNT_W 2
`define ST_RUN 2'h0
`define ST_ENTER 2'h1
`define ST_SLEEP 2'h2
`define ST_EXIT 2'h3
`endif

// ==== logic/sram_array.v ====
/*
 byte-lane storage for the sram port, data and parity per lane.
 assumes one write or one read request per clock; read data registered.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sram_burst_map.vh"
module sram_array (
    input wire clk_i,
    input wire [`ADDR_W-1:0] addr_i,
    input wire [`LANES-1:0] lane_we_i,
    input wire [`DATA_W-1:0] wdata_i,
    input wire [`LANES-1:0] wpar_i,
    output reg [`DATA_W-1:0] rdata_o,
    output reg [`LANES-1:0] rpar_o
);
    reg [`LANE_W:0] mem [0:`LANES*`WORDS-1];
    genvar g;
    generate
        for (g = 0; g < `LANES; g = g + 1) begin : lane
            localparam [1:0] LANE_IDX = g;
            always @(posedge clk_i) begin
                if (lane_we_i[g]) begin
                    mem[{addr_i, LANE_IDX}] <=
                        {wpar_i[g], wdata_i[g*`LANE_W +: `LANE_W]};
                end
                {rpar_o[g], rdata_o[g*`LANE_W +: `LANE_W]} <=
                    mem[{addr_i, LANE_IDX}];
            end
        end
    endgenerate
endmodule // sram_array
`default_nettype wire

// ==== logic/sram_burst.v ====
/*
 device side of a flow-through burst sram port: load, burst, write with
 lane selects, deselect, stall and sleep. assumes the controller keeps
 its own timing duties; asynchronous pins are synchronised here.
*/
// What this block does
// RULE1: one loaded address serves up to four accesses via burst counter
// RULE2: burst order input low means linear, high means interleaved
// RULE3: bursts touch only the two low address bits and wrap
// RULE4: qualified advance high steps the counter regardless of selects
// RULE5: write strobe captured at burst start, type kept for the burst
// RULE6: write starts on qualified load with selects active, strobe low
// RULE7: recognised write three-states data and parity regardless of enable
// RULE8: write data latched one clock after address; new access same cycle, but a read loaded then outputs the old word at the write address
// RULE9: only selected lanes with their parity get written
// RULE10: any lane mix allowed; no lanes selected means write abort
// RULE11: controller must not drive data lines while outputs are active
// RULE12: advance high in burst write ignores selects and strobe
// RULE13: controller presents lane selects again each burst write cycle
// RULE14: interleaved access k uses start xor k on low bits
// RULE15: linear access adds one modulo four on low bits
// RULE16: sleep asynchronous; outputs off, inputs ignored, contents kept
// RULE17: two cycles to enter sleep and two to leave it
// RULE18: access pending at sleep entry is dropped
// RULE19: controller deselects around sleep and two cycles after it
// RULE20: unqualified clock edge holds all internal state; the pin synchronisers and sleep sequencer still advance on it
// RULE21: output enable async, masked on writes, needs read and select
// RULE22: after reset deselected with data and parity three-stated
// RULE23: load with any select inactive deselects; advance continues it
`timescale 1ns/1ps
`default_nettype none
`include "sram_burst_map.vh"
module sram_burst (
    input wire clk_i,
    input wire rst_n_i,
    input wire clock_qualify_n_i,
    input wire chip_select_first_n_i,
    input wire chip_select_second_i,
    input wire chip_select_third_n_i,
    input wire advance_or_load_i,
    input wire write_strobe_n_i,
    input wire [`LANES-1:0] byte_lane_select_n_i,
    input wire burst_order_select_i,
    input wire sleep_request_i,
    input wire output_drive_enable_n_i,
    input wire [`ADDR_W-1:0] addr_i,
    input wire [`DATA_W-1:0] data_i,
    input wire [`LANES-1:0] parity_i,
    output reg [`DATA_W-1:0] data_o,
    output reg [`LANES-1:0] parity_o,
    output wire data_oe_o,
    output wire asleep_o
);
    // synchronisers for the asynchronous pins
    reg zz_meta;
    reg zz_sync;
    reg oe_meta;
    reg oe_n_sync;

    // sleep sequencer
    reg [1:0] state;
    reg [1:0] next_state;
    reg [`ZZ_CNT_W-1:0] zz_cnt;

    // burst state latched at load
    reg active;
    reg is_write;
    reg interleave;
    reg [`ADDR_W-1:0] base_addr;
    reg [`BURST_W-1:0] start_low;
    reg [`BURST_W-1:0] step;

    // data phase
    reg wr_pend;
    reg [`ADDR_W-1:0] wr_addr;
    reg rd_valid;
    wire [`LANES-1:0] lane_we;

    // array port
    wire [`DATA_W-1:0] arr_data;
    wire [`LANES-1:0] arr_par;
    wire run;
    wire qual;
    wire sel_all;
    wire load;
    wire adv;
    wire [`BURST_W-1:0] low_now;
    wire [`ADDR_W-1:0] cur_addr;
    wire [`ADDR_W-1:0] acc_addr;
    wire [`BURST_W-1:0] step_next;
    reg [`ADDR_W-1:0] arr_addr;
    reg [`ADDR_W-1:0] hold_addr;
    reg [2:0] op;
    reg next_wr_pend;
    reg next_rd_valid;

    // one code per kind of edge the port can see
    localparam [2:0] OP_SLEEP = 3'h0;
    localparam [2:0] OP_STALL = 3'h1;
    localparam [2:0] OP_DESELECT = 3'h2;
    localparam [2:0] OP_READ = 3'h3;
    localparam [2:0] OP_WRITE = 3'h4;
    localparam [2:0] OP_NEXT_IDLE = 3'h5;
    localparam [2:0] OP_NEXT_READ = 3'h6;
    localparam [2:0] OP_NEXT_WRITE = 3'h7;

    // sleep and output enable pins from the controller side are async here
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            zz_meta <= 1'b0;
            zz_sync <= 1'b0;
            oe_meta <= 1'b1;
            oe_n_sync <= 1'b1;
        end else begin
            zz_meta <= sleep_request_i; // RULE16
            zz_sync <= zz_meta;
            oe_meta <= output_drive_enable_n_i; // RULE21
            oe_n_sync <= oe_meta;
        end
    end

    // sleep sequencer: two cycles each way
    always @* begin
        next_state = state;
        case (state)
            `ST_RUN: if (zz_sync) next_state = `ST_ENTER;
            `ST_ENTER: if (zz_cnt == `ZZ_CYC - 1) next_state = `ST_SLEEP;
            `ST_SLEEP: if (!zz_sync) next_state = `ST_EXIT;
            `ST_EXIT: if (zz_cnt == `ZZ_CYC - 1) next_state = `ST_RUN;
            default: next_state = `ST_RUN;
        endcase
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= `ST_RUN;
            zz_cnt <= {`ZZ_CNT_W{1'b0}};
        end else begin
            state <= next_state; // RULE17
            if (next_state != state)
                zz_cnt <= {`ZZ_CNT_W{1'b0}};
            else if (state == `ST_ENTER || state == `ST_EXIT)
                zz_cnt <= zz_cnt + 1'b1;
        end
    end

    assign run = (state == `ST_RUN) && !zz_sync; // RULE16
    assign qual = run && !clock_qualify_n_i; // RULE20
    assign sel_all = !chip_select_first_n_i && chip_select_second_i &&
        !chip_select_third_n_i;
    assign load = qual && !advance_or_load_i;
    assign adv = qual && advance_or_load_i; // RULE4 RULE12

    // an advance edge accesses the step after the one already used
    assign step_next = step + `BURST_ONE;
    assign low_now = interleave ? (start_low ^ step_next) // RULE14
                                : (start_low + step_next); // RULE15
    assign cur_addr = {base_addr[`ADDR_W-1:`BURST_W], low_now}; // RULE3
    assign acc_addr = load ? addr_i : cur_addr;

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            active <= 1'b0; // RULE22
            is_write <= 1'b0;
            interleave <= 1'b0;
            base_addr <= {`ADDR_W{1'b0}};
            start_low <= {`BURST_W{1'b0}};
            step <= {`BURST_W{1'b0}};
        end else if (!run) begin
            active <= 1'b0; // RULE18
        end else if (load) begin
            active <= sel_all; // RULE6 RULE23
            is_write <= !write_strobe_n_i; // RULE5
            interleave <= burst_order_select_i; // RULE2
            base_addr <= addr_i; // RULE1
            start_low <= addr_i[`BURST_W-1:0];
            step <= {`BURST_W{1'b0}};
        end else if (adv) begin
            step <= step + `BURST_ONE; // RULE1 RULE3
        end
    end

    // classify the edge once; continue rows reuse the type latched at
    // load, so selects and strobe are not looked at while advancing
    always @* begin
        if (!run)
            op = OP_SLEEP; // RULE16
        else if (clock_qualify_n_i)
            op = OP_STALL; // RULE20
        else if (load) begin
            if (!sel_all)
                op = OP_DESELECT; // RULE23
            else if (write_strobe_n_i)
                op = OP_READ;
            else
                op = OP_WRITE; // RULE6
        end else if (!active)
            op = OP_NEXT_IDLE; // RULE23
        else if (is_write)
            op = OP_NEXT_WRITE; // RULE12
        else
            op = OP_NEXT_READ; // RULE4
    end

    always @* begin
        next_wr_pend = 1'b0;
        next_rd_valid = 1'b0;
        case (op)
            OP_SLEEP: begin
                next_wr_pend = 1'b0; // RULE18
                next_rd_valid = 1'b0;
            end
            OP_STALL: begin
                next_wr_pend = wr_pend; // RULE20
                next_rd_valid = rd_valid;
            end
            OP_DESELECT, OP_NEXT_IDLE: begin
                next_wr_pend = 1'b0;
                next_rd_valid = 1'b0;
            end
            OP_READ, OP_NEXT_READ: begin
                next_wr_pend = 1'b0;
                next_rd_valid = 1'b1;
            end
            OP_WRITE, OP_NEXT_WRITE: begin
                next_wr_pend = 1'b1; // RULE8
                next_rd_valid = 1'b0;
            end
            default: begin
                next_wr_pend = 1'b0;
                next_rd_valid = 1'b0;
            end
        endcase
    end

    // data phase follows the address by one qualified edge
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_pend <= 1'b0;
            rd_valid <= 1'b0;
            wr_addr <= {`ADDR_W{1'b0}};
        end else begin
            wr_pend <= next_wr_pend; // RULE8 RULE18
            rd_valid <= next_rd_valid;
            if (qual)
                wr_addr <= acc_addr;
        end
    end

    // lane selects are sampled with the data, every cycle of a burst
    genvar lane_g;
    generate
        for (lane_g = 0; lane_g < `LANES; lane_g = lane_g + 1) begin : lane_en
            assign lane_we[lane_g] = qual && wr_pend &&
                !byte_lane_select_n_i[lane_g]; // RULE9 RULE10 RULE13
        end
    endgenerate

    // a dead edge rereads the last address, so a stalled or sleeping
    // port keeps showing the same word
    always @* begin
        if (qual && wr_pend)
            arr_addr = wr_addr;
        else if (qual)
            arr_addr = acc_addr;
        else
            arr_addr = hold_addr;
    end

    always @(posedge clk_i) begin
        if (!rst_n_i)
            hold_addr <= {`ADDR_W{1'b0}};
        else
            hold_addr <= arr_addr; // RULE20
    end

    sram_array u_array (
        .clk_i(clk_i),
        .addr_i(arr_addr),
        .lane_we_i(lane_we),
        .wdata_i(data_i),
        .wpar_i(parity_i),
        .rdata_o(arr_data),
        .rpar_o(arr_par)
    );

    // the array's output register is the data flop; a second stage
    // would put read data one edge behind the address, unlike flow-through
    always @* begin
        data_o = arr_data;
        parity_o = arr_par;
    end

    assign data_oe_o = run && rd_valid && !wr_pend && !oe_n_sync; // RULE7 RULE21
    assign asleep_o = (state != `ST_RUN);
endmodule // sram_burst
`default_nettype wire

// ==== testbench/sram_burst_sva.sv ====
/*
 port checker for sram_burst, bound below.
 assumes one clock clk_i with rst_n_i as its reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sram_burst_map.vh"
module sram_burst_sva (
    input wire clk_i,
    input wire rst_n_i,
    input wire clock_qualify_n_i,
    input wire chip_select_first_n_i,
    input wire chip_select_second_i,
    input wire chip_select_third_n_i,
    input wire advance_or_load_i,
    input wire write_strobe_n_i,
    input wire sleep_request_i,
    input wire output_drive_enable_n_i,
    input wire [`DATA_W-1:0] data_o,
    input wire data_oe_o,
    input wire asleep_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire go = !clock_qualify_n_i && !sleep_request_i && !asleep_o;
    wire sel = !chip_select_first_n_i && chip_select_second_i &&
        !chip_select_third_n_i;
    wire load = go && !advance_or_load_i;
    sequence oe_low; !output_drive_enable_n_i [*4]; endsequence
    sequence rd_load; load && sel && write_strobe_n_i; endsequence
    sequence woken; asleep_o [*2] ##[1:5] !asleep_o; endsequence
    a_reset_quiet: assert property ($rose(rst_n_i) |-> !data_oe_o && !asleep_o)
        else $error("reset left outputs on");
    a_read_drive: assert property (oe_low ##0 rd_load |=> data_oe_o)
        else $error("read not driven");
    a_write_hiz: assert property (load && sel && !write_strobe_n_i |=> !data_oe_o)
        else $error("write drove data");
    a_deselect_hiz: assert property (load && !sel |=> !data_oe_o)
        else $error("deselect drove data");
    a_oe_off: assert property (output_drive_enable_n_i [*4] |-> !data_oe_o)
        else $error("drove with enable high");
    a_sleep_off: assert property (asleep_o |-> !data_oe_o)
        else $error("drove while asleep");
    a_stall_hold: assert property (clock_qualify_n_i && data_oe_o |=> $stable(data_o))
        else $error("stall changed data");
    a_sleep_enter: assert property ($rose(sleep_request_i) |-> ##[1:5] asleep_o)
        else $error("sleep not entered");
    a_sleep_exit: assert property ($fell(sleep_request_i) |-> woken)
        else $error("sleep exit timing");
endmodule // sram_burst_sva
bind sram_burst sram_burst_sva chk (.clk_i, .rst_n_i, .clock_qualify_n_i,
    .chip_select_first_n_i, .chip_select_second_i, .chip_select_third_n_i,
    .advance_or_load_i, .write_strobe_n_i, .sleep_request_i,
    .output_drive_enable_n_i, .data_o, .data_oe_o, .asleep_o);
`default_nettype wire

// ==== testbench/sram_ctrl_model.sv ====
/*
 controller side of the shared data lines: write data with lane parity.
 assumes the bench raises phase_i for the data cycle of each write.
*/
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_model (
    input wire clk_i,
    input wire phase_i,
    input wire [31:0] word_i,
    output wire [31:0] data_o,
    output wire [3:0] parity_o
);
    reg [31:0] last = 32'h0;
    always @(posedge clk_i) last <= data_o;
    // released lines move every cycle so a stale value never looks valid
    assign data_o = phase_i ? word_i : ~last;
    assign parity_o = {^data_o[31:24], ^data_o[23:16], ^data_o[15:8],
        ^data_o[7:0]};
endmodule // sram_ctrl_model
`default_nettype wire

// ==== testbench/sram_burst_bench.sv ====
/*
 bench for sram_burst: burst writes and reads, stall, enable, sleep.
 assumes sram_ctrl_model drives the write data lines.
*/
`timescale 1ns/1ps
`default_nettype none
module sram_burst_bench;
    reg clk_i = 0, rst_n_i = 0, cq = 0, sel = 0, adv = 0, ws = 1;
    reg ord = 0, zz = 0, oe_n = 0, ph = 0;
    reg [3:0] ln = 4'hF;
    reg [17:0] a = 18'h0;
    reg [31:0] w = 32'h0;
    reg [31:0] mir [0:3];
    wire [31:0] d, q;
    wire [3:0] p, qp;
    wire oe, slp;
    integer n_errors = 0, samples_checked = 0, k, i, j;
    initial forever #5 clk_i = ~clk_i;
    sram_ctrl_model ctl (.clk_i, .phase_i(ph), .word_i(w), .data_o(d),
        .parity_o(p));
    sram_burst dut (.clk_i, .rst_n_i, .clock_qualify_n_i(cq),
        .chip_select_first_n_i(!sel), .chip_select_second_i(sel),
        .chip_select_third_n_i(!sel), .advance_or_load_i(adv),
        .write_strobe_n_i(ws), .byte_lane_select_n_i(ln),
        .burst_order_select_i(ord), .sleep_request_i(zz),
        .output_drive_enable_n_i(oe_n), .addr_i(a), .data_i(d),
        .parity_i(p), .data_o(q), .parity_o(qp), .data_oe_o(oe),
        .asleep_o(slp));
    task chk(input [47:0] nm, input [31:0] e, input [31:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("unexpected %0s: expected %h, seen %h", nm, e, g);
            end
        end
    endtask
    task cyc(input c, s, v, r, input [3:0] l, input [31:0] x, input h);
        begin
            cq <= c; sel <= s; adv <= v; ws <= r; ln <= l; w <= x; ph <= h;
            @(posedge clk_i);
            #1;
        end
    endtask
    task wburst(input [17:0] ad, input o, input [15:0] lm, input [31:0] b);
        begin
            ord <= o;
            a <= ad;
            cyc(0, 1, 0, 0, 4'hF, 0, 0);
            for (i = 0; i < 4; i = i + 1) begin
                j = (o ? ad[1:0] ^ i : ad[1:0] + i) & 3;
                // selects and strobe dropped on advance; last beat deselects
                cyc(0, 0, i < 3, 1, lm[4*i+:4], b + i, 1);
                chk("wr_oe", 0, oe);
                for (k = 0; k < 4; k = k + 1)
                    if (!lm[4*i+k]) mir[j][8*k+:8] = w[8*k+:8];
            end
        end
    endtask
    task rburst(input [17:0] ad, input o);
        begin
            ord <= o;
            a <= ad;
            for (i = 0; i < 4; i = i + 1) begin
                j = (o ? ad[1:0] ^ i : ad[1:0] + i) & 3;
                // first beat loads; data follow the load edge directly
                cyc(0, i == 0, i != 0, 1, 4'hF, 0, 0);
                chk("data", mir[j], q);
                chk("par", {^mir[j][31:24], ^mir[j][23:16], ^mir[j][15:8],
                    ^mir[j][7:0]}, qp);
                chk("drive", !oe_n, oe);
                if (i == 1) begin
                    cyc(1, 1, 0, 0, 4'h0, 0, 0);
                    chk("stall", mir[j], q);
                end
            end
            cyc(0, 0, 0, 1, 4'hF, 0, 0);
            chk("ds_oe", 0, oe);
        end
    endtask
    task nap;
        begin
            zz <= 1;
            for (i = 0; i < 6 && !slp; i = i + 1) @(posedge clk_i) #1;
            chk("sleep", 1, slp);
            cyc(0, 1, 0, 0, 4'h0, 32'h0, 1);
            repeat (3) cyc(0, 1, 0, 0, 4'h0, 32'h0, 1);
            chk("sl_oe", 0, oe);
            zz <= 0;
            cyc(0, 0, 0, 1, 4'hF, 0, 0);
            for (i = 0; i < 8 && slp; i = i + 1) @(posedge clk_i) #1;
            chk("wake", 1, !slp && i >= 1);
            repeat (2) @(posedge clk_i);
        end
    endtask
    task final_report;
        begin
            $display("checks %0d errors %0d", samples_checked, n_errors);
            if (n_errors == 0 && samples_checked > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        #100000;
        n_errors = n_errors + 1;
        final_report;
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1;
        repeat (3) @(posedge clk_i);
        #1 chk("rst_oe", 0, oe);
        wburst(18'h2A5D1, 0, 16'h0, 32'h11223344);
        rburst(18'h2A5D1, 0);
        wburst(18'h2A5D2, 1, 16'h5FE0, 32'hA0B1C2D3);
        rburst(18'h2A5D2, 1);
        oe_n <= 1;
        // the enable pin is synchronised, so let it settle first
        repeat (2) cyc(0, 0, 0, 1, 4'hF, 0, 0);
        rburst(18'h2A5D3, 0);
        oe_n <= 0;
        nap;
        rburst(18'h2A5D0, 1);
        final_report;
    end
endmodule // sram_burst_bench
`default_nettype wire
